// *** lcs_pkg.sv ***
// lcs_pkg: command codes, register indices, field layouts, reset values
// assumes: shared by the command decoder and its parameter router
`default_nettype none
package lcs_pkg;

	// ----------------------------------------------------------------
	// command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_SYSTEM_SETUP    = 8'h40;
	localparam logic [7:0] CMD_STANDBY         = 8'h53;
	localparam logic [7:0] CMD_DISPLAY_OFF     = 8'h58;
	localparam logic [7:0] CMD_DISPLAY_ON      = 8'h59;
	localparam logic [7:0] CMD_SCROLL          = 8'h44;
	localparam logic [7:0] CMD_CURSOR_SHAPE    = 8'h5d;
	localparam logic [5:0] CMD_CURSOR_DIR_TOP  = 6'h13;
	localparam logic [7:0] CMD_LAYER_OVERLAY   = 8'h5b;
	localparam logic [7:0] CMD_CHARGEN_ADDR    = 8'h5c;
	localparam logic [7:0] CMD_PIXEL_SCROLL    = 8'h5a;

	// ----------------------------------------------------------------
	// register indices and parameter counts
	// ----------------------------------------------------------------
	localparam logic [5:0] REG_SYS_BASE    = 6'h00;
	localparam logic [5:0] REG_DISP_ATTR   = 6'h0a;
	localparam logic [5:0] REG_SCROLL_BASE = 6'h0b;
	localparam logic [5:0] REG_CSR_BASE    = 6'h15;
	localparam logic [5:0] REG_CSR_DIR     = 6'h17;
	localparam logic [5:0] REG_OVERLAY     = 6'h18;
	localparam logic [5:0] REG_CG_BASE     = 6'h19;
	localparam logic [5:0] REG_PIX_SCROLL  = 6'h1b;
	localparam int         NUM_REGS        = 28;
	localparam logic [3:0] CNT_SYSTEM      = 4'h8;
	localparam logic [3:0] CNT_SCROLL      = 4'ha;
	localparam logic [3:0] CNT_TWO         = 4'h2;
	localparam logic [3:0] CNT_ONE         = 4'h1;
	localparam logic [3:0] CNT_NONE        = 4'h0;

	// ----------------------------------------------------------------
	// write masks: bits shown as zero read back as zero
	// ----------------------------------------------------------------
	localparam logic [7:0] MASK_REG00   = 8'h2d;
	localparam logic [7:0] MASK_REG01   = 8'h8f;
	localparam logic [7:0] MASK_LOW4    = 8'h0f;
	localparam logic [7:0] MASK_CSRH    = 8'h8f;
	localparam logic [7:0] MASK_DIR     = 8'h03;
	localparam logic [7:0] MASK_OVERLAY = 8'h1f;
	localparam logic [7:0] MASK_PIXEL   = 8'h07;
	localparam logic [7:0] MASK_FULL    = 8'hff;
	localparam logic [7:0] REG_RESET    = 8'h00;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       wr;
		logic       addr_cmd;
		logic [7:0] data;
	} lcs_host_wr_t;

	typedef struct packed {
		logic       en;
		logic [5:0] idx;
		logic [7:0] data;
	} lcs_reg_wr_t;

endpackage
`default_nettype wire

// *** lcs_param_map.sv ***
// lcs_param_map: turns (active command, parameter number) into a
// register index and a write mask; purely combinational
// assumes: command code held by the decoder, count starting at zero
`default_nettype none
module lcs_param_map
	import lcs_pkg::*;
(
	input  wire logic [7:0] cmd_in,
	input  wire logic [3:0] count_in,
	output logic            valid_out,
	output logic [5:0]      idx_out,
	output logic [7:0]      mask_out
);
	import lcs_pkg::*;

	always_comb begin
		valid_out = 1'b0;
		idx_out   = REG_SYS_BASE;
		mask_out  = MASK_FULL;
		unique case (cmd_in)
			CMD_SYSTEM_SETUP: begin
				valid_out = count_in < CNT_SYSTEM;
				idx_out   = REG_SYS_BASE + {2'b00, count_in};
				if (count_in == 4'h0)
					mask_out = MASK_REG00;
				else if (count_in == 4'h1)
					mask_out = MASK_REG01;
				else if (count_in == 4'h2)
					mask_out = MASK_LOW4;
			end
			CMD_DISPLAY_OFF, CMD_DISPLAY_ON: begin
				valid_out = count_in < CNT_ONE;
				idx_out   = REG_DISP_ATTR;
			end
			CMD_SCROLL: begin
				valid_out = count_in < CNT_SCROLL;
				idx_out   = REG_SCROLL_BASE + {2'b00, count_in};
			end
			CMD_CURSOR_SHAPE: begin
				valid_out = count_in < CNT_TWO;
				idx_out   = REG_CSR_BASE + {2'b00, count_in};
				mask_out  = (count_in == 4'h0) ? MASK_LOW4 : MASK_CSRH;
			end
			CMD_LAYER_OVERLAY: begin
				valid_out = count_in < CNT_ONE;
				idx_out   = REG_OVERLAY;
				mask_out  = MASK_OVERLAY;
			end
			CMD_CHARGEN_ADDR: begin
				valid_out = count_in < CNT_TWO;
				idx_out   = REG_CG_BASE + {2'b00, count_in};
			end
			CMD_PIXEL_SCROLL: begin
				valid_out = count_in < CNT_ONE;
				idx_out   = REG_PIX_SCROLL;
				mask_out  = MASK_PIXEL;
			end
			default: begin
				valid_out = 1'b0;
			end
		endcase
	end

endmodule
`default_nettype wire

// *** lcs_cmd_decoder.sv ***
// lcs_cmd_decoder: system and display control command decoder
// assumes: host strobes already synchronised to CORE_CLK_IN, one-cycle
// write pulses; the register image is exposed as flat ports
`default_nettype none

// Notes on behaviour
// RL1 - setup command leaves standby, whatever put the device there
// RL2 - setup takes eight parameters; normal operation after the eighth
// RL3 - first setup parameter keeps bits 5,3,2,0 in register 00h
// RL4 - second setup parameter keeps bit 7 and bits 3-0 in register 01h
// RL5 - standby command is one byte with no parameters
// RL6 - display off takes one byte, stored whole in register 0Ah
// RL7 - scroll takes up to ten parameters into registers 0Bh to 14h
// RL8 - host sends ninth and tenth scroll parameters only for dual panel
// RL9 - cursor shape: width low nibble, then mode bit 7 and height
// RL10 - cursor direction has no parameters; low two bits to 17h
// RL11 - overlay parameter into 18h: layer select, modes, composition
// RL12 - chargen address command: low byte then high byte
// RL13 - pixel scroll keeps only the three low bits
// RL14 - address high write is a command, low is a parameter
// RL15 - display off 58h and on 59h, each with one attribute byte
// RL16 - parameters counted per command; new command restarts the count
// RL17 - bits shown as zero store silently and read back zero
module lcs_cmd_decoder
	import lcs_pkg::*;
(
	input  wire logic                  CORE_CLK_IN,
	input  wire logic                  RST_IN,
	input  wire logic                  HOST_WR_IN,
	input  wire logic                  HOST_RD_IN,
	input  wire logic                  HOST_A0_IN,
	input  wire logic [7:0]            HOST_DATA_IN,
	input  wire logic [5:0]            READ_IDX_IN,
	output logic      [7:0]            READ_DATA_OUT,
	output logic                       STANDBY_OUT,
	output logic                       NORMAL_OP_OUT,
	output logic                       DISPLAY_ON_OUT,
	output logic      [8*28-1:0]       REGS_OUT
);
	import lcs_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                     standby;
		logic                     normal_op;
		logic                     display_on;
		logic                     setup_seen;
		logic [7:0]               cmd;
		logic [3:0]               count;
		logic [7:0]               read_data;
		logic [NUM_REGS-1:0][7:0] regs;
	} lcs_state_t;

	lcs_state_t   st_reg;
	lcs_state_t   st_next;
	lcs_host_wr_t host_wr;
	lcs_reg_wr_t  reg_wr;
	logic         map_valid;
	logic [5:0]   map_idx;
	logic [7:0]   map_mask;
	logic         is_cmd;
	logic         is_param;
	logic         is_read;

	// ----------------------------------------------------------------
	// host strobe decode
	// ----------------------------------------------------------------
	// RL14 address line split
	assign host_wr = '{wr: HOST_WR_IN, addr_cmd: HOST_A0_IN,
		data: HOST_DATA_IN};
	assign is_cmd   = host_wr.wr && host_wr.addr_cmd;
	assign is_param = host_wr.wr && !host_wr.addr_cmd;
	// read with address high returns the selected register
	assign is_read  = HOST_RD_IN && HOST_A0_IN;

	// ----------------------------------------------------------------
	// parameter routing
	// ----------------------------------------------------------------
	// RL16 route by count
	lcs_param_map u_map (
		.cmd_in   (st_reg.cmd),
		.count_in (st_reg.count),
		.valid_out(map_valid),
		.idx_out  (map_idx),
		.mask_out (map_mask)
	);

	// RL17 zero bits masked
	assign reg_wr = '{en: is_param && map_valid, idx: map_idx,
		data: host_wr.data & map_mask};

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		if (is_cmd) begin
			// RL16 new command restarts
			st_next.cmd   = host_wr.data;
			st_next.count = 4'h0;
			unique case (host_wr.data)
				// RL1 leave standby
				CMD_SYSTEM_SETUP: begin
					st_next.standby    = 1'b0;
					st_next.setup_seen = 1'b1;
					st_next.normal_op  = 1'b0;
				end
				// RL5 standby, no parameters
				CMD_STANDBY: begin
					st_next.standby   = 1'b1;
					st_next.normal_op = 1'b0;
				end
				// RL15 off and on codes
				CMD_DISPLAY_OFF:
					st_next.display_on = 1'b0;
				CMD_DISPLAY_ON:
					st_next.display_on = 1'b1;
				default: begin
					// RL10 direction bits direct
					if (host_wr.data[7:2] == CMD_CURSOR_DIR_TOP)
						st_next.regs[REG_CSR_DIR] =
							host_wr.data & MASK_DIR;
				end
			endcase
		end else if (is_param) begin
			// saturating so a long burst never wraps onto a register
			if (st_reg.count != 4'hf)
				st_next.count = st_reg.count + 4'h1;
			// RL3 RL4 RL6 RL7 RL9 RL11 RL12 RL13 store
			if (reg_wr.en)
				st_next.regs[reg_wr.idx] = reg_wr.data;
			// RL2 normal after eighth
			if (st_reg.cmd == CMD_SYSTEM_SETUP && st_reg.setup_seen &&
			    st_reg.count == CNT_SYSTEM - 4'h1) begin
				st_next.normal_op  = 1'b1;
				st_next.setup_seen = 1'b0;
			end
		end
		// register read lands one cycle later
		if (is_read)
			st_next.read_data = (READ_IDX_IN < 6'(NUM_REGS)) ?
				st_reg.regs[READ_IDX_IN[4:0]] : REG_RESET;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// power-up lands in standby until the first setup command
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			st_reg            <= '0;
			st_reg.standby    <= 1'b1;
			st_reg.cmd        <= CMD_STANDBY;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign READ_DATA_OUT  = st_reg.read_data;
	assign STANDBY_OUT    = st_reg.standby;
	assign NORMAL_OP_OUT  = st_reg.normal_op;
	assign DISPLAY_ON_OUT = st_reg.display_on;
	assign REGS_OUT       = st_reg.regs;

endmodule
`default_nettype wire

// *** lcs_host_model.sv ***
// lcs_host_model: host processor on the indirect command port
// assumes: bench calls its tasks; strobes change just after an edge
`default_nettype none
module lcs_host_model
	import lcs_pkg::*;
(
	input  wire logic             clk_in,
	output var  lcs_host_wr_t     hw_out,
	output var  logic             rd_out,
	output var  logic [5:0]       idx_out
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		hw_out = '0;
		rd_out = 1'b0;
		idx_out = '0;
	end

	// address line picks command or parameter
	task automatic send(input logic [7:0] c, input int n,
			input logic [7:0] p [10]);
		@(posedge clk_in);
		hw_out <= '{1'b1, 1'b1, c};
		for (int i = 0; i < n; i++) begin
			@(posedge clk_in);
			hw_out <= '{1'b1, 1'b0, p[i]};
		end
		@(posedge clk_in);
		// released bus shows the inverse, never a stale byte
		hw_out <= '{1'b0, hw_out.addr_cmd, ~hw_out.data};
	endtask

	task automatic rd(input logic [5:0] i);
		@(posedge clk_in);
		rd_out <= 1'b1;
		hw_out.addr_cmd <= 1'b1;
		idx_out <= i;
		@(posedge clk_in);
		rd_out <= 1'b0;
	endtask
endmodule
`default_nettype wire

// *** lcs_cmd_decoder_monitor.sv ***
// lcs_cmd_decoder_monitor: port-level checks of the decoder
// assumes: bound into lcs_cmd_decoder, one clock, async reset high
`default_nettype none
module lcs_cmd_decoder_monitor
	import lcs_pkg::*;
(
	input  wire logic             CORE_CLK_IN,
	input  wire logic             RST_IN,
	input  wire logic             HOST_WR_IN,
	input  wire logic             HOST_RD_IN,
	input  wire logic             HOST_A0_IN,
	input  wire logic [7:0]       HOST_DATA_IN,
	input  wire logic [5:0]       READ_IDX_IN,
	input  wire logic [7:0]       READ_DATA_OUT,
	input  wire logic             STANDBY_OUT,
	input  wire logic             NORMAL_OP_OUT,
	input  wire logic             DISPLAY_ON_OUT,
	input  wire logic [8*28-1:0]  REGS_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       cmd;
	logic [7:0] sel;
	assign cmd = HOST_WR_IN && HOST_A0_IN;
	// indices of 28 and up slice out of range; a_read_answer uses sel only below 28
	assign sel = REGS_OUT[{READ_IDX_IN, 3'b000} +: 8];
	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (RST_IN);

	a_setup_wakes: assert property (
		cmd && HOST_DATA_IN == CMD_SYSTEM_SETUP |=> !STANDBY_OUT)
		else $error("setup left standby set");
	a_standby_enter: assert property (
		cmd && HOST_DATA_IN == CMD_STANDBY |=> STANDBY_OUT)
		else $error("standby not entered");
	a_disp_switch: assert property (
		cmd && HOST_DATA_IN[7:1] == 7'h2c
		|=> DISPLAY_ON_OUT == $past(HOST_DATA_IN[0]))
		else $error("display switch wrong");
	a_dir_store: assert property (
		cmd && HOST_DATA_IN[7:2] == CMD_CURSOR_DIR_TOP
		|=> REGS_OUT[191:184] == {6'h00, $past(HOST_DATA_IN[1:0])})
		else $error("cursor direction not stored");
	a_disp_param: assert property (
		cmd && HOST_DATA_IN[7:1] == 7'h2c ##1 HOST_WR_IN && !HOST_A0_IN
		|=> REGS_OUT[87:80] == $past(HOST_DATA_IN))
		else $error("display attribute not stored");
	a_zero_bits: assert property (
		(REGS_OUT[7:0] & ~MASK_REG00) == 8'h00 &&
		(REGS_OUT[15:8] & ~MASK_REG01) == 8'h00 &&
		REGS_OUT[223:219] == 5'h00)
		else $error("zero bit set");
	a_read_answer: assert property (
		HOST_RD_IN && HOST_A0_IN && !HOST_WR_IN && READ_IDX_IN < 6'd28
		|=> READ_DATA_OUT == $past(sel))
		else $error("read data wrong");
	a_quiet_hold: assert property (
		!HOST_WR_IN |=> $stable(REGS_OUT))
		else $error("registers moved without a write");
	a_normal_rise: assert property (
		$rose(NORMAL_OP_OUT) |-> $past(HOST_WR_IN) && !$past(HOST_A0_IN))
		else $error("normal operation without a parameter");
endmodule

bind lcs_cmd_decoder lcs_cmd_decoder_monitor i_mon (
	.CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .HOST_WR_IN(HOST_WR_IN),
	.HOST_RD_IN(HOST_RD_IN), .HOST_A0_IN(HOST_A0_IN),
	.HOST_DATA_IN(HOST_DATA_IN), .READ_IDX_IN(READ_IDX_IN),
	.READ_DATA_OUT(READ_DATA_OUT), .STANDBY_OUT(STANDBY_OUT),
	.NORMAL_OP_OUT(NORMAL_OP_OUT), .DISPLAY_ON_OUT(DISPLAY_ON_OUT),
	.REGS_OUT(REGS_OUT));
`default_nettype wire

// *** lcs_cmd_decoder_bench.sv ***
// lcs_cmd_decoder_bench: command sequences with expected register images
// assumes: host model drives the port, monitor bound to the decoder
`default_nettype none
`define CHK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin \
	n_fail++; $display("BAD %0t %s", $time, msg); end end
module lcs_cmd_decoder_bench
	import lcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic            clk = 1'b0;
	logic            rst = 1'b1;
	lcs_host_wr_t    hw;
	logic            rd, stby, norm, don;
	logic [5:0]      idx;
	logic [7:0]      rdata;
	logic [8*28-1:0] regs;
	logic [7:0]      p [10];
	int              n_fail = 0, n_tests = 0, cyc = 0;

	lcs_host_model i_host (.clk_in(clk), .hw_out(hw), .rd_out(rd),
		.idx_out(idx));
	lcs_cmd_decoder i_dut (.CORE_CLK_IN(clk), .RST_IN(rst),
		.HOST_WR_IN(hw.wr), .HOST_RD_IN(rd), .HOST_A0_IN(hw.addr_cmd),
		.HOST_DATA_IN(hw.data), .READ_IDX_IN(idx), .READ_DATA_OUT(rdata),
		.STANDBY_OUT(stby), .NORMAL_OP_OUT(norm), .DISPLAY_ON_OUT(don),
		.REGS_OUT(regs));

	always #5 clk = ~clk;
	// a hang is cut short well past the fewer than a hundred cycles needed
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			end_sim();
		end
	end

	function automatic logic [7:0] rg(input int k);
		return regs[8*k +: 8];
	endfunction

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic one(input logic [7:0] c, a, b, input int n, k,
			input logic [7:0] e1, e2);
		p[0] = a;
		p[1] = b;
		i_host.send(c, n, p);
		#1;
		`CHK(rg(k), e1, "first parameter")
		if (n == 2) `CHK(rg(k + 1), e2, "second parameter")
	endtask

	initial begin
		p = '{8'hff, 8'hff, 8'hff, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55,
			8'h00, 8'h00};
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		`CHK({stby, norm, don}, 3'b100, "reset flags")
		i_host.send(CMD_SYSTEM_SETUP, 3, p);
		#1 `CHK({stby, norm}, 2'b00, "partial setup")
		i_host.send(CMD_SYSTEM_SETUP, 8, p);
		#1 `CHK(norm, 1'b1, "normal after eight")
		`CHK(rg(0), 8'h2d, "reg00 bits")
		`CHK(rg(1), 8'h8f, "reg01 bits")
		`CHK(rg(2), 8'h0f, "reg02 bits")
		`CHK({rg(3), rg(7)}, 16'h1155, "setup tail")
		i_host.rd(6'h00);
		#1 `CHK(rdata, 8'h2d, "read back")
		$display("setup test done");
		i_host.send(CMD_STANDBY, 1, p);
		#1 `CHK({stby, rg(0)}, 9'h12d, "standby stray")
		i_host.send(CMD_SYSTEM_SETUP, 0, p);
		#1 `CHK(stby, 1'b0, "wake")
		$display("standby test done");
		for (int i = 0; i < 10; i++) p[i] = 8'(8'h10 + i);
		i_host.send(CMD_SCROLL, 10, p);
		#1;
		for (int i = 0; i < 10; i++)
			`CHK(rg(11 + i), 8'(8'h10 + i), "scroll")
		one(CMD_SCROLL, 8'hee, 8'h00, 1, 11, 8'hee, 8'h00);
		`CHK(rg(12), 8'h11, "restart")
		$display("scroll test done");
		one(CMD_DISPLAY_ON, 8'ha5, 8'h00, 1, 10, 8'ha5, 8'h00);
		`CHK(don, 1'b1, "display on")
		one(CMD_DISPLAY_OFF, 8'h3c, 8'h00, 1, 10, 8'h3c, 8'h00);
		`CHK(don, 1'b0, "display off")
		one(CMD_CURSOR_SHAPE, 8'hff, 8'hff, 2, 21, 8'h0f, 8'h8f);
		one(CMD_LAYER_OVERLAY, 8'hff, 8'h00, 1, 24, 8'h1f, 8'h00);
		one(CMD_CHARGEN_ADDR, 8'h34, 8'h12, 2, 25, 8'h34, 8'h12);
		one(CMD_PIXEL_SCROLL, 8'hff, 8'h00, 1, 27, 8'h07, 8'h00);
		for (logic [7:0] d = 0; d < 4; d++)
			one(8'h4c + d, 8'hff, 8'h00, 1, 23, d, 8'h00);
		$display("display test done");
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		#1 `CHK({stby, norm, rg(0)}, 10'h200, "reset again")
		$display("reset test done");
		end_sim();
	end
endmodule
`undef CHK
`default_nettype wire
